// [atc_pkg.sv]
// Package with frame layout, command codes and acknowledge codes for the telemetry command handler.
package atc_pkg;
  localparam int          FRAME_BITS   = 32;
  localparam logic [1:0]  START_CODE   = 2'h1;
  localparam logic [1:0]  CMD_READ     = 2'h3;
  localparam logic [1:0]  CMD_WR_HOLD  = 2'h1;
  localparam logic [1:0]  CMD_WR_COMMIT = 2'h0;
  localparam logic [3:0]  TYPE_IOUT    = 4'h2;
  localparam logic [3:0]  TYPE_TEMP    = 4'h3;
  localparam logic [3:0]  TYPE_VRESET  = 4'h4;
  localparam logic [3:0]  TYPE_PMODE   = 4'h5;
  localparam logic [3:0]  TYPE_STATUS  = 4'he;
  localparam logic [3:0]  TYPE_VERSION = 4'hf;
  localparam logic [3:0]  SEL_A        = 4'h0;
  localparam logic [3:0]  SEL_B        = 4'h1;
  localparam logic [3:0]  SEL_ALL      = 4'hf;
  localparam logic [1:0]  ACK_GOOD     = 2'h0;
  localparam logic [1:0]  ACK_BUSY     = 2'h1;
  localparam logic [1:0]  ACK_BADCRC   = 2'h2;
  localparam logic [1:0]  ACK_INVALID  = 2'h3;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] STATUS_WMASK = 16'h70fe;
  localparam logic [15:0] VERSION_WORD = 16'h0000;
  localparam logic [15:0] PMODE_WORD   = 16'h0000;
  localparam logic [15:0] READ_FILL    = 16'hffff;
  localparam logic [4:0]  RSVD_TAIL    = 5'h1f;
  localparam logic [2:0]  CRC_INIT     = 3'h0;
  localparam logic [4:0]  BIT_LAST     = 5'h1f;

  typedef struct packed {
    logic [1:0]  start;
    logic [1:0]  cmd;
    logic        group;
    logic [3:0]  ctype;
    logic [3:0]  sel;
    logic [15:0] data;
    logic [2:0]  crc;
  } atc_req_t;

  typedef struct packed {
    logic [1:0]  ack;
    logic        rsvd;
    logic [4:0]  summary;
    logic [15:0] data;
    logic [4:0]  tail;
    logic [2:0]  crc;
  } atc_rsp_t;

  typedef struct packed {
    logic [15:0] iout;
    logic [15:0] temp;
  } atc_tele_t;

  // Serial check code step for x^3 + x + 1.
  function automatic logic [2:0] atc_crc_step(input logic [2:0] c, input logic b);
    logic fb;
    fb = c[2] ^ b;
    return {c[1], c[0] ^ fb, fb};
  endfunction
endpackage

// [atc_handler.sv]
// Slave-side command handler for the voltage scaling serial bus of a two-channel regulator.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Current read returns 16-bit, 10 mA steps.
// - Current MSB forced zero; channels A, B only.
// - Temperature read returns signed 0.1 degree steps.
// - Temperature of selected channel A or B.
// - Voltage reset pulses boot request per channel.
// - Power mode accepted, writes ignored, reads zero.
// - Status resets zero, write one clears bits in STATUS_WMASK only.
// - Version read broadcast only, returns zero.
// - Frames carry three-bit check code both ways.
// - Acknowledge encodes good, busy, bad check, invalid.
// - Warning holds response line low until cleared.
// - Latch-off or disabled ignores bus entirely.
module atc_handler
  import atc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        bus_clk,
  input  wire logic        bus_mdata,
  output logic             bus_sdata,
  input  wire logic [15:0] iout_a,
  input  wire logic [15:0] iout_b,
  input  wire logic [15:0] temp_a,
  input  wire logic [15:0] temp_b,
  input  wire logic [15:0] warn_set,
  input  wire logic [4:0]  summary_in,
  input  wire logic        busy,
  input  wire logic        latch_off,
  input  wire logic        conv_en,
  output logic [1:0]       boot_voltage_req,
  output logic [15:0]      status_word
);
  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_SEND, ST_TAIL} atc_state_t;

  logic [2:0]  clk_sync_ff, md_sync_ff;
  logic [1:0]  blk_sync_ff;
  logic        clk_rise, clk_fall, blocked;

  atc_state_t  state_ff, nxt_state;
  logic [4:0]  cnt_ff, nxt_cnt;
  logic [31:0] sh_ff, nxt_sh;
  logic [2:0]  crc_ff, nxt_crc;
  logic [31:0] rsp_ff, nxt_rsp;
  logic [15:0] stat_ff, nxt_stat;
  logic [1:0]  boot_ff, nxt_boot;
  logic        sd_ff, nxt_sd;
  atc_req_t    req;
  atc_rsp_t    rsp;
  atc_tele_t   tele;
  logic [2:0]  rcrc;
  logic        chan_sel, bcast, wr, rd;

  assign clk_rise = clk_sync_ff[1] & ~clk_sync_ff[2];
  assign clk_fall = ~clk_sync_ff[1] & clk_sync_ff[2];
  assign blocked  = blk_sync_ff[1];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clk_sync_ff <= 3'h0;
      md_sync_ff  <= 3'h7;
      blk_sync_ff <= 2'h3;
    end
    else
    begin
      clk_sync_ff <= {clk_sync_ff[1:0], bus_clk};
      md_sync_ff  <= {md_sync_ff[1:0], bus_mdata};
      blk_sync_ff <= {blk_sync_ff[0], latch_off | ~conv_en};
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_sh    = sh_ff;
    nxt_crc   = crc_ff;
    nxt_rsp   = rsp_ff;
    nxt_boot  = 2'h0;
    nxt_stat  = stat_ff | warn_set;
    nxt_sd    = sd_ff;
    req       = atc_req_t'(sh_ff);
    rcrc      = CRC_INIT;
    tele      = '0;
    rsp       = '0;
    chan_sel  = 1'b0;
    bcast     = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_sd = ~(|stat_ff);
        if (!blocked && clk_rise && md_sync_ff[2:1] == 2'b00)
        begin
          nxt_state = ST_RECV;
          nxt_cnt   = 5'h1;
          nxt_sh    = 32'h0;
          nxt_crc   = atc_crc_step(CRC_INIT, 1'b0);
        end
      end
      ST_RECV:
      begin
        if (blocked)
          nxt_state = ST_IDLE;
        else if (clk_rise)
        begin
          nxt_sh = {sh_ff[30:0], md_sync_ff[2]};
          if (cnt_ff < 5'd29)
            nxt_crc = atc_crc_step(crc_ff, md_sync_ff[2]);
          nxt_cnt = cnt_ff + 5'h1;
          if (cnt_ff == BIT_LAST)
          begin
            req      = atc_req_t'(nxt_sh);
            chan_sel = req.sel == SEL_A || req.sel == SEL_B;
            bcast    = req.sel == SEL_ALL;
            rd       = req.cmd == CMD_READ;
            wr       = req.cmd == CMD_WR_HOLD || req.cmd == CMD_WR_COMMIT;
            tele.iout = (req.sel == SEL_B) ? iout_b : iout_a;
            tele.temp = (req.sel == SEL_B) ? temp_b : temp_a;
            rsp.data  = READ_FILL;
            if (crc_ff != req.crc || req.start != START_CODE)
              rsp.ack = ACK_BADCRC;
            else if (req.group)
              rsp.ack = ACK_INVALID;
            else if (busy)
              rsp.ack = ACK_BUSY;
            else
            begin
              rsp.ack = ACK_INVALID;
              case (req.ctype)
                TYPE_IOUT:
                  if (rd && chan_sel)
                  begin
                    rsp.ack  = ACK_GOOD;
                    rsp.data = {1'b0, tele.iout[14:0]};
                  end
                TYPE_TEMP:
                  if (rd && chan_sel)
                  begin
                    rsp.ack  = ACK_GOOD;
                    rsp.data = tele.temp;
                  end
                TYPE_VRESET:
                  if (wr && (chan_sel || bcast))
                  begin
                    rsp.ack  = ACK_GOOD;
                    nxt_boot = bcast ? 2'h3 : (req.sel == SEL_B ? 2'h2 : 2'h1);
                  end
                TYPE_PMODE:
                  if (chan_sel || bcast)
                  begin
                    rsp.ack = ACK_GOOD;
                    if (rd)
                      rsp.data = PMODE_WORD;
                  end
                TYPE_STATUS:
                  if (chan_sel || bcast)
                  begin
                    rsp.ack = ACK_GOOD;
                    if (rd)
                      rsp.data = stat_ff;
                    else
                      nxt_stat = (stat_ff & ~(req.data & STATUS_WMASK)) | warn_set;
                  end
                TYPE_VERSION:
                  if (rd && bcast)
                  begin
                    rsp.ack  = ACK_GOOD;
                    rsp.data = VERSION_WORD;
                  end
                default:
                  rsp.ack = ACK_INVALID;
              endcase
            end
            rsp.summary = {summary_in[4], |nxt_stat, summary_in[2:1], 1'b0};
            rsp.tail    = RSVD_TAIL;
            rcrc = CRC_INIT;
            for (int i = 31; i > 2; i--)
              rcrc = atc_crc_step(rcrc, rsp[i]);
            rsp.crc   = rcrc;
            nxt_rsp   = rsp;
            nxt_state = ST_SEND;
            nxt_cnt   = 5'h0;
          end
        end
      end
      ST_SEND:
      begin
        if (blocked)
          nxt_state = ST_IDLE;
        else if (clk_fall)
        begin
          nxt_sd  = rsp_ff[31];
          nxt_rsp = {rsp_ff[30:0], 1'b1};
        end
        else if (clk_rise)
        begin
          nxt_cnt = cnt_ff + 5'h1;
          if (cnt_ff == BIT_LAST)
            nxt_state = ST_TAIL;
        end
      end
      ST_TAIL:
      begin
        // The last response bit stays on the line until the link clock falls.
        if (blocked || clk_fall)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 5'h0;
      sh_ff    <= 32'h0;
      crc_ff   <= CRC_INIT;
      rsp_ff   <= 32'h0;
      stat_ff  <= STATUS_RESET;
      boot_ff  <= 2'h0;
      sd_ff    <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      sh_ff    <= nxt_sh;
      crc_ff   <= nxt_crc;
      rsp_ff   <= nxt_rsp;
      stat_ff  <= nxt_stat;
      boot_ff  <= nxt_boot;
      sd_ff    <= nxt_sd;
    end
  end

  assign bus_sdata        = sd_ff;
  assign boot_voltage_req = boot_ff;
  assign status_word      = stat_ff;
endmodule
`default_nettype wire

// [atc_host_model.sv]
// Host model that drives request frames and collects response frames.
`timescale 1ns/1ps
`default_nettype none
module atc_host_model
  import atc_pkg::*;
(
  output logic     bus_clk,
  output logic     bus_mdata,
  input wire logic bus_sdata
);
  initial
  begin
    bus_clk = 1'b0;
    bus_mdata = 1'b1;
  end
  function automatic logic [2:0] crc(input logic [31:0] w);
    logic [2:0] c;
    logic       fb;
    c = 3'h0;
    for (int i = 31; i >= 3; i--)
    begin
      fb = c[2] ^ w[i];
      c = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction
  // The link clock stands low between frames; a response bit is taken late in its period.
  task automatic xfer(input logic [31:0] q, output logic [31:0] r);
    #37;
    for (int i = 0; i < 64; i++)
    begin
      bus_mdata = (i < 32) ? q[31 - i] : 1'b1;
      #400 bus_clk = 1'b1;
      #390 if (i >= 32) r[63 - i] = bus_sdata;
      #10 bus_clk = 1'b0;
    end
    #5000;
  endtask
endmodule
`default_nettype wire

// [atc_handler_sva.sv]
// Checker for the ports of the telemetry command handler.
`timescale 1ns/1ps
`default_nettype none
module atc_handler_sva
  import atc_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        bus_clk,
  input wire logic        bus_sdata,
  input wire logic [15:0] warn_set,
  input wire logic        busy,
  input wire logic        latch_off,
  input wire logic        conv_en,
  input wire logic [1:0]  boot_voltage_req,
  input wire logic [15:0] status_word
);
  logic [7:0] idle_ff;
  logic [7:0] nxt_idle;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Counts cycles since the link clock was last high.
  always_comb nxt_idle = bus_clk ? 8'h00 : idle_ff + {7'h0, ~&idle_ff};
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      idle_ff <= 8'h00;
    else
      idle_ff <= nxt_idle;
  boot_pulse_a: assert property (|boot_voltage_req |=> boot_voltage_req == 2'h0)
    else $error("boot pulse too long");
  boot_cause_a: assert property (|boot_voltage_req |-> conv_en && !latch_off && !busy)
    else $error("boot pulse while barred");
  status_set_a: assert property ((status_word & ~$past(status_word) & ~$past(warn_set)) == 16'h0000)
    else $error("status set without warning");
  status_clear_a: assert property (|(~status_word & $past(status_word)) |-> idle_ff < 8'd10)
    else $error("status cleared outside a frame");
  warn_capture_a: assert property (|warn_set |=>
    (status_word & $past(warn_set) & STATUS_WMASK) == ($past(warn_set) & STATUS_WMASK))
    else $error("warning not latched");
  blocked_quiet_a: assert property ((latch_off || !conv_en) [*8] |->
    bus_sdata == ~|$past(status_word) && boot_voltage_req == 2'h0)
    else $error("activity while blocked");
  alert_idle_a: assert property (idle_ff == 8'd40 |-> bus_sdata == ~|$past(status_word))
    else $error("idle line level wrong");
  alert_rise_a: assert property ($rose(|status_word) && idle_ff > 8'd40 |-> ##[1:3] !bus_sdata)
    else $error("alert not raised");
endmodule
`default_nettype wire

// [test_atc_handler.sv]
// Self-checking bench for the telemetry command handler.
`timescale 1ns/1ps
`default_nettype none
module test_atc_handler
  import atc_pkg::*;
;
  logic        clk = 1'b0, nrst, bus_clk, bus_mdata, bus_sdata, busy, latch_off, conv_en;
  logic [15:0] iout_a, iout_b, temp_a, temp_b, warn_set, status_word;
  logic [1:0]  boot_voltage_req;
  int          errors, comparisons, pa, pb;
  atc_handler dut_u (.clk(clk), .nrst(nrst), .bus_clk(bus_clk), .bus_mdata(bus_mdata), .bus_sdata(bus_sdata),
    .iout_a(iout_a), .iout_b(iout_b), .temp_a(temp_a), .temp_b(temp_b), .warn_set(warn_set),
    .summary_in(5'h04), .busy(busy), .latch_off(latch_off), .conv_en(conv_en),
    .boot_voltage_req(boot_voltage_req), .status_word(status_word));
  atc_host_model host_u (.bus_clk(bus_clk), .bus_mdata(bus_mdata), .bus_sdata(bus_sdata));
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    pa += int'(boot_voltage_req[0]);
    pb += int'(boot_voltage_req[1]);
  end
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic frame(input logic [1:0] c, input logic [3:0] t, input logic [3:0] s, input logic [15:0] d,
                       input logic [2:0] bad, input logic [1:0] ea, input logic [15:0] ed);
    atc_req_t q;
    atc_rsp_t r;
    q = {START_CODE, c, 1'b0, t, s, d, 3'h0};
    q.crc = host_u.crc(q) ^ bad;
    host_u.xfer(q, r);
    cmp("ack", 16'(ea), 16'(r.ack));
    cmp("check code", 16'(host_u.crc(r)), 16'(r.crc));
    if (c == CMD_READ && ea == ACK_GOOD) cmp("data", ed, r.data);
  endtask
  task automatic rd(input logic [3:0] t, input logic [3:0] s, input logic [1:0] ea, input logic [15:0] ed);
    frame(CMD_READ, t, s, READ_FILL, 3'h0, ea, ed);
  endtask
  task automatic wr(input logic [3:0] t, input logic [3:0] s, input logic [15:0] d, input logic [2:0] bad,
                    input logic [1:0] ea);
    frame(CMD_WR_COMMIT, t, s, d, bad, ea, 16'h0000);
  endtask
  task automatic t_tele();
    rd(TYPE_IOUT, SEL_A, ACK_GOOD, 16'h1043);
    rd(TYPE_IOUT, SEL_B, ACK_GOOD, 16'h4350);
    rd(TYPE_TEMP, SEL_A, ACK_GOOD, 16'hff62);
    rd(TYPE_TEMP, SEL_B, ACK_GOOD, 16'h05dc);
    rd(TYPE_IOUT, SEL_ALL, ACK_INVALID, 16'h0000);
    rd(TYPE_VERSION, SEL_A, ACK_INVALID, 16'h0000);
    rd(TYPE_VERSION, SEL_ALL, ACK_GOOD, 16'h0000);
    wr(TYPE_IOUT, SEL_A, 16'h0000, 3'h0, ACK_INVALID);
    $display("telemetry test done");
  endtask
  task automatic t_boot();
    wr(TYPE_VRESET, SEL_ALL, 16'h0000, 3'h0, ACK_GOOD);
    wr(TYPE_VRESET, SEL_B, 16'h0000, 3'h0, ACK_GOOD);
    @(posedge clk) busy <= 1'b1;
    wr(TYPE_VRESET, SEL_A, 16'h0000, 3'h0, ACK_BUSY);
    @(posedge clk) busy <= 1'b0;
    wr(TYPE_VRESET, SEL_A, 16'h0000, 3'h4, ACK_BADCRC);
    cmp("pulses a", 16'h0001, 16'(pa));
    cmp("pulses b", 16'h0002, 16'(pb));
    $display("boot test done");
  endtask
  task automatic t_status();
    @(posedge clk) warn_set <= 16'h7002;
    @(posedge clk) warn_set <= 16'h0000;
    repeat (4) @(posedge clk);
    cmp("status", 16'h7002, status_word);
    cmp("alert", 16'h0000, 16'(bus_sdata));
    rd(TYPE_STATUS, SEL_A, ACK_GOOD, 16'h7002);
    wr(TYPE_STATUS, SEL_ALL, 16'h1002, 3'h0, ACK_GOOD);
    cmp("status", 16'h6000, status_word);
    frame(CMD_WR_HOLD, TYPE_STATUS, SEL_B, 16'h6000, 3'h0, ACK_GOOD, 16'h0000);
    cmp("alert", 16'h0001, 16'(bus_sdata));
    wr(TYPE_PMODE, SEL_ALL, 16'h1234, 3'h0, ACK_GOOD);
    rd(TYPE_PMODE, SEL_B, ACK_GOOD, 16'h0000);
    $display("status test done");
  endtask
  task automatic t_block();
    logic [31:0] r;
    @(posedge clk) latch_off <= 1'b1;
    repeat (8) @(posedge clk);
    host_u.xfer({START_CODE, CMD_READ, 1'b0, TYPE_IOUT, SEL_A, READ_FILL, 3'h0}, r);
    cmp("silent line", 16'hffff, r[31:16] & r[15:0]);
    @(posedge clk) latch_off <= 1'b0;
    conv_en <= 1'b0;
    repeat (8) @(posedge clk);
    host_u.xfer({START_CODE, CMD_READ, 1'b0, TYPE_IOUT, SEL_A, READ_FILL, 3'h0}, r);
    cmp("silent line", 16'hffff, r[31:16] & r[15:0]);
    $display("blocked test done");
  endtask
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    nrst = 1'b0;
    busy = 1'b0;
    latch_off = 1'b0;
    conv_en = 1'b1;
    warn_set = 16'h0000;
    iout_a = 16'h1043;
    iout_b = 16'hc350;
    temp_a = 16'hff62;
    temp_b = 16'h05dc;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("status", 16'h0000, status_word);
    t_tele();
    t_boot();
    t_status();
    t_block();
    close_out();
  end
  initial
  begin
    #3000000;
    errors++;
    close_out();
  end
endmodule
bind atc_handler atc_handler_sva chk_u (.clk(clk), .nrst(nrst), .bus_clk(bus_clk), .bus_sdata(bus_sdata),
  .warn_set(warn_set), .busy(busy), .latch_off(latch_off), .conv_en(conv_en),
  .boot_voltage_req(boot_voltage_req), .status_word(status_word));
`default_nettype wire
